// ===== ssp_pkg.sv
package ssp_pkg;

    // serial word geometry
    localparam int         WORD_BITS  = 16;
    localparam logic [3:0] CNT_FIRST  = 4'h0;
    localparam logic [3:0] CNT_LAST   = 4'hF;
    localparam logic [3:0] CNT_STEP   = 4'h1;

    // command word field positions
    localparam int TOGGLE_POS = 15;
    localparam int PARITY_POS = 14;
    localparam int BANK_POS   = 13;
    localparam int ADDR_MSB   = 12;
    localparam int ADDR_LSB   = 10;
    localparam int DATA_MSB   = 9;
    localparam int DATA_LSB   = 0;

    // register addresses inside a bank
    localparam logic [2:0] ADDR_SEL   = 3'h0;
    localparam logic [2:0] ADDR_GCR   = 3'h6;

    // output register selects (low three select bits)
    localparam logic [2:0] SOA_STATUS = 3'h0;
    localparam logic [2:0] SOA_FAULT  = 3'h1;

    // reset values
    localparam logic [9:0]  CFG_RST   = 10'h000;
    localparam logic [3:0]  SOA_RST   = 4'h0;
    localparam logic [15:0] WORD_RST  = 16'h0000;

    // number of bits passed through the pin synchroniser
    localparam int SYNC_W = 6;

    typedef struct packed {
        logic       watchdog_toggle_bit;
        logic       parity;
        logic       bank;
        logic [2:0] addr;
        logic [9:0] data;
    } ssp_cmd_t;

    typedef struct packed {
        logic       ov;
        logic       uv;
        logic       por;
        logic [1:0] retry_full;
        logic [1:0] fault;
    } ssp_stat_t;

    // true when a word holds an odd number of ones
    function automatic logic ssp_odd(input logic [15:0] w);
        return ^w;
    endfunction : ssp_odd

endpackage : ssp_pkg

// ===== ssp_sync.sv
`timescale 1ns/1ps
module ssp_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule : ssp_sync

// ===== ssp_command_port.sv
// Behaviour
// - words shift most significant bit first
// - last complete sixteen-bit word of a frame is the command
// - top bit carries watchdog toggle, not data
// - second bit makes word parity even; checked
// - decode bank, address and ten data bits
// - bad length or parity discards whole frame
// - input reappears on output one word later
// - select fall starts shifting out and in
// - first output word chosen by previous select
// - second output word follows first shifted word
// - select rise validates, then latches good word
// - after select rise output floats, status refreshed
// - thirteen writable per-bank registers; those at address 1 do not read back
// - normal mode sets prewarning flag on heat
// - prewarning clears by fault read once cool
// - output-on bits report channels in real time
`timescale 1ns/1ps
module ssp_command_port (
    input  wire logic               MCLK,
    input  wire logic               RESET,
    input  wire logic               SCLK,
    input  wire logic               CHIP_SELECT_N,
    input  wire logic               SI,
    output logic                    SO,
    output logic                    SO_OE,
    input  wire logic               RESET_N_PIN,
    input  wire logic               NORMAL_MODE,
    input  wire logic               TEMP_ABOVE_PREWARN,
    input  wire logic [1:0]         OUT_ABOVE_HALF,
    input  wire ssp_pkg::ssp_stat_t STATUS_IN,
    input  wire logic [11:0]        FAULT_IN,
    output logic [1:0][7:0][9:0]    CFG,
    output logic                    WATCHDOG_TOGGLE_BIT,
    output logic                    THERMAL_PREWARNING_FLAG,
    output logic                    PARITY_FAULT,
    output logic                    LATCH_STROBE
);

    // link side, shift clock domain
    logic        live_q;
    logic [3:0]  cnt_q;
    logic [15:0] rx_q;
    logic [15:0] last_q;
    logic        any_q;
    logic        perr_q;
    logic        tog_q;
    logic        so_q;
    logic        so_live_q;

    // core side, MCLK domain
    logic [ssp_pkg::SYNC_W-1:0] sync_d;
    logic [ssp_pkg::SYNC_W-1:0] sync_q;
    logic                       cs_prev_q;
    logic                       tog_seen_q;
    logic [1:0][7:0][9:0]       cfg_q;
    logic [3:0]                 soa_q;
    logic                       wd_q;
    logic                       pf_q;
    logic                       warn_q;
    logic                       latch_q;
    logic [15:0]                out_word_q;

    wire        link_clr = RESET | CHIP_SELECT_N;
    wire [3:0]  cnt_eff  = live_q ? cnt_q : ssp_pkg::CNT_FIRST;
    wire [15:0] rx_next  = {rx_q[14:0], SI};
    wire        word_end = (cnt_eff == ssp_pkg::CNT_LAST);
    wire [15:0] tx_src   = any_q ? last_q : out_word_q;

    // live_q marks that the current frame has seen a rising edge; it is
    // cleared by chip select so counters need no clock while idle
    always_ff @(posedge SCLK or posedge link_clr) begin
        if (link_clr) begin
            live_q <= 1'b0;
        end else begin
            live_q <= 1'b1;
        end
    end

    always_ff @(posedge SCLK or posedge RESET) begin
        if (RESET) begin
            cnt_q  <= ssp_pkg::CNT_FIRST;
            rx_q   <= ssp_pkg::WORD_RST;
            last_q <= ssp_pkg::WORD_RST;
            any_q  <= 1'b0;
            perr_q <= 1'b0;
            tog_q  <= 1'b0;
        end else begin
            cnt_q  <= 4'(cnt_eff + ssp_pkg::CNT_STEP);
            rx_q   <= rx_next;
            any_q  <= word_end | (live_q & any_q);
            perr_q <= (word_end & ssp_pkg::ssp_odd(rx_next))
                    | (live_q & perr_q);
            if (word_end) begin
                last_q <= rx_next;
            end
            if (!live_q) begin
                tog_q <= ~tog_q;
            end
        end
    end

    // output bit changes on the falling edge, one word behind the input
    always_ff @(negedge SCLK or posedge link_clr) begin
        if (link_clr) begin
            so_q      <= 1'b0;
            so_live_q <= 1'b0;
        end else begin
            so_q      <= tx_src[~cnt_q];
            so_live_q <= 1'b1;
        end
    end

    // before the first falling edge the pin shows the selected word's msb
    assign SO    = so_live_q ? so_q : out_word_q[15];
    assign SO_OE = ~CHIP_SELECT_N;

    // select and reset pin pass inverted so a cleared synchroniser reads idle
    assign sync_d = {~CHIP_SELECT_N, ~RESET_N_PIN, TEMP_ABOVE_PREWARN,
                     OUT_ABOVE_HALF, tog_q};

    ssp_sync #(
        .W   (ssp_pkg::SYNC_W)
    ) u_sync (
        .clk (MCLK),
        .rst (RESET),
        .d   (sync_d),
        .q   (sync_q)
    );

    wire       cs_s   = ~sync_q[5];
    wire       rpin_s = ~sync_q[4];
    wire       temp_s = sync_q[3];
    wire [1:0] out_s  = sync_q[2:1];
    wire       tog_s  = sync_q[0];

    // link registers are read only once select has risen and the shift
    // clock has stopped, so they are stable when sampled here
    wire cs_rise   = cs_s & ~cs_prev_q;
    wire frame_new = tog_s ^ tog_seen_q;
    wire frame_end = cs_rise & frame_new;
    wire len_ok    = any_q & (cnt_q == ssp_pkg::CNT_FIRST);
    wire frame_ok  = frame_end & len_ok & ~perr_q & rpin_s;

    ssp_pkg::ssp_cmd_t cmd;
    assign cmd = ssp_pkg::ssp_cmd_t'(last_q);

    wire wr_sel  = frame_ok & (cmd.addr == ssp_pkg::ADDR_SEL);
    wire gcr_b1  = cmd.bank & (cmd.addr == ssp_pkg::ADDR_GCR);
    wire wr_cfg  = frame_ok & ~wr_sel & ~gcr_b1;
    wire warn_set = NORMAL_MODE & temp_s;
    wire warn_clr = frame_end & (soa_q[2:0] == ssp_pkg::SOA_FAULT)
                  & ~temp_s;

    wire [5:0] fault_ch  = soa_q[3] ? FAULT_IN[11:6] : FAULT_IN[5:0];
    wire [8:0] stat_body = {STATUS_IN, out_s};
    wire [8:0] flt_body  = {warn_q, 2'b00, fault_ch};
    wire [8:0] cfg_body  = cfg_q[soa_q[3]][soa_q[2:0]][8:0];
    wire [8:0] body      = (soa_q[2:0] == ssp_pkg::SOA_STATUS) ? stat_body
                         : (soa_q[2:0] == ssp_pkg::SOA_FAULT)  ? flt_body
                         : cfg_body;
    wire [15:0] sel_word = {wd_q, pf_q, soa_q, NORMAL_MODE, body};

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            cs_prev_q  <= 1'b1;
            tog_seen_q <= 1'b0;
            latch_q    <= 1'b0;
            warn_q     <= 1'b0;
            out_word_q <= ssp_pkg::WORD_RST;
        end else begin
            cs_prev_q  <= cs_s;
            latch_q    <= frame_ok;
            warn_q     <= warn_set | (warn_q & ~warn_clr);
            if (cs_rise) begin
                tog_seen_q <= tog_s;
            end
            // frozen while selected; the two MCLK cycles of synchroniser delay after the
            // select edge are the only window for a late refresh
            if (cs_s) begin
                out_word_q <= sel_word;
            end
        end
    end

    // the reset pin clears the register file through its synchroniser
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            cfg_q <= {16{ssp_pkg::CFG_RST}};
            soa_q <= ssp_pkg::SOA_RST;
            wd_q  <= 1'b0;
            pf_q  <= 1'b0;
        end else if (!rpin_s) begin
            cfg_q <= {16{ssp_pkg::CFG_RST}};
            soa_q <= ssp_pkg::SOA_RST;
            wd_q  <= 1'b0;
            pf_q  <= 1'b0;
        end else begin
            if (frame_end) begin
                pf_q <= perr_q;
            end
            if (frame_ok) begin
                wd_q <= cmd.watchdog_toggle_bit;
            end
            if (wr_sel) begin
                soa_q <= {cmd.bank, cmd.data[2:0]};
            end
            if (wr_cfg) begin
                cfg_q[cmd.bank][cmd.addr] <= cmd.data;
            end
        end
    end

    assign CFG                     = cfg_q;
    assign WATCHDOG_TOGGLE_BIT     = wd_q;
    assign THERMAL_PREWARNING_FLAG = warn_q;
    assign PARITY_FAULT            = pf_q;
    assign LATCH_STROBE            = latch_q;

    // checks, shift clock domain
    property p_word_wrap;
        @(posedge SCLK) disable iff (RESET)
        live_q && cnt_q == 4'hF ##1 live_q |-> cnt_q == 4'h0 && any_q;
    endproperty
    a_word_wrap: assert property (p_word_wrap)
        else $error("word counter did not wrap after sixteen bits");

    property p_parity_sticky;
        @(posedge SCLK) disable iff (RESET)
        word_end && ssp_pkg::ssp_odd(rx_next) |=> perr_q;
    endproperty
    a_parity_sticky: assert property (p_parity_sticky)
        else $error("odd word did not raise the parity error");

    property p_daisy;
        @(posedge SCLK) disable iff (RESET)
        word_end |=> last_q == $past(rx_next);
    endproperty
    a_daisy: assert property (p_daisy)
        else $error("completed word not held for the output");

    // checks, MCLK domain
    property p_len_discard;
        @(posedge MCLK) disable iff (RESET)
        cs_rise && (cnt_q != 4'h0 || perr_q) |=> !latch_q;
    endproperty
    a_len_discard: assert property (p_len_discard)
        else $error("frame with bad length or parity was latched");

    property p_latch_ok;
        @(posedge MCLK) disable iff (RESET)
        frame_end && any_q && cnt_q == 4'h0 && !perr_q && rpin_s
        |=> latch_q;
    endproperty
    a_latch_ok: assert property (p_latch_ok)
        else $error("valid frame was not latched");

    property p_wd_bit;
        @(posedge MCLK) disable iff (RESET)
        latch_q && rpin_s |-> wd_q == $past(last_q[15]);
    endproperty
    a_wd_bit: assert property (p_wd_bit)
        else $error("watchdog bit not taken from the top bit");

    property p_cfg_write;
        @(posedge MCLK) disable iff (RESET)
        wr_cfg && rpin_s |=> cfg_q[$past(cmd.bank)][$past(cmd.addr)]
                             == $past(cmd.data);
    endproperty
    a_cfg_write: assert property (p_cfg_write)
        else $error("data field not written to the addressed register");

    property p_soa_sel;
        @(posedge MCLK) disable iff (RESET)
        wr_sel && rpin_s |=> soa_q == {$past(cmd.bank), $past(cmd.data[2:0])};
    endproperty
    a_soa_sel: assert property (p_soa_sel)
        else $error("output select not taken from the select word");

    property p_warn_set;
        @(posedge MCLK) disable iff (RESET)
        NORMAL_MODE && temp_s |=> warn_q ##1 warn_q || !temp_s || warn_clr;
    endproperty
    a_warn_set: assert property (p_warn_set)
        else $error("prewarning flag not set while hot");

    property p_warn_hold;
        @(posedge MCLK) disable iff (RESET)
        warn_q && !frame_end |=> warn_q;
    endproperty
    a_warn_hold: assert property (p_warn_hold)
        else $error("prewarning flag cleared without a fault read");

    property p_refresh;
        @(posedge MCLK) disable iff (RESET)
        cs_s && soa_q[2:0] == ssp_pkg::SOA_STATUS ##1 cs_s
        |-> out_word_q[1:0] == $past(out_s);
    endproperty
    a_refresh: assert property (p_refresh)
        else $error("idle output word not refreshed from channel state");

    c_latch:    cover property (@(posedge MCLK) disable iff (RESET)
                                latch_q);
    c_perr:     cover property (@(posedge MCLK) disable iff (RESET)
                                frame_end && perr_q);
    c_warn_clr: cover property (@(posedge MCLK) disable iff (RESET)
                                warn_q && warn_clr && !warn_set);
    c_two_word: cover property (@(posedge SCLK) disable iff (RESET)
                                live_q && any_q && word_end);

endmodule : ssp_command_port

// ===== ssp_spi_master.sv
`timescale 1ns/1ps
module ssp_spi_master (
    output logic      sclk,
    output logic      cs_n,
    output logic      si,
    input  wire logic so
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        si   = 1'b0;
    end

    // clock runs only inside frames; idle data is inverted, never stale
    task automatic xfer(input logic [31:0] tx, input int n,
                        output logic [31:0] rx);
        rx = '0;
        #3.7 cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            si = tx[i];
            #62.5 sclk = 1'b1;
            rx = {rx[30:0], so};
            #62.5 sclk = 1'b0;
        end
        #31 cs_n = 1'b1;
        si = ~si;
    endtask : xfer
endmodule : ssp_spi_master

// ===== switch_spi_command_port_tb_top.sv
`timescale 1ns/1ps
module switch_spi_command_port_tb_top;
    logic                mclk;
    logic                reset;
    logic                sclk;
    logic                cs_n;
    logic                si;
    logic                so;
    logic                so_oe;
    logic                rst_n_pin;
    logic                nm;
    logic                temp_hi;
    logic [1:0]          oah;
    ssp_pkg::ssp_stat_t  status_in;
    logic [11:0]         fault_in;
    logic [1:0][7:0][9:0] cfg;
    logic                wd_bit;
    logic                warn_flag;
    logic                par_fault;
    logic                strobe;
    int                  n_errors;
    int                  check_count;
    int                  m_cfg [2][8];
    logic                wd;
    logic [31:0]         rx;

    always #5 mclk = ~mclk;

    ssp_command_port dut_u (
        .MCLK(mclk), .RESET(reset), .SCLK(sclk), .CHIP_SELECT_N(cs_n),
        .SI(si), .SO(so), .SO_OE(so_oe), .RESET_N_PIN(rst_n_pin),
        .NORMAL_MODE(nm), .TEMP_ABOVE_PREWARN(temp_hi),
        .OUT_ABOVE_HALF(oah), .STATUS_IN(status_in), .FAULT_IN(fault_in),
        .CFG(cfg), .WATCHDOG_TOGGLE_BIT(wd_bit),
        .THERMAL_PREWARNING_FLAG(warn_flag), .PARITY_FAULT(par_fault),
        .LATCH_STROBE(strobe)
    );

    ssp_spi_master mst_u (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so));

    task automatic close_out;
        if (n_errors == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    function automatic logic [15:0] mk(input logic w, input logic b,
                                       input logic [2:0] a,
                                       input logic [9:0] d);
        return {w, ^{w, b, a, d}, b, a, d};
    endfunction : mk

    task automatic run(input logic [31:0] tx, input int n, input int ns,
                       output logic [31:0] r);
        int c;
        c = 0;
        mst_u.xfer(tx, n, r);
        repeat (12) begin
            @(posedge mclk);
            #1;
            if (strobe === 1'b1)
                c++;
        end
        chk(c, ns);
        chk(so_oe, 1'b0);
        wd = ~wd;
    endtask : run

    task automatic wr(input logic b, input logic [2:0] a,
                      input logic [9:0] d, output logic [31:0] r);
        logic w;
        w = wd;
        run({16'h0000, mk(wd, b, a, d)}, 16, 1, r);
        chk(wd_bit, w);
        if (a != 3'h0) begin
            m_cfg[b][a] = d;
            chk(cfg[b][a], m_cfg[b][a]);
        end
    endtask : wr

    initial begin
        #500000;
        n_errors++;
        close_out;
    end

    initial begin
        logic [9:0]  d;
        logic [15:0] w;
        mclk = 1'b0;
        reset = 1'b1;
        rst_n_pin = 1'b1;
        nm = 1'b0;
        temp_hi = 1'b0;
        oah = 2'h0;
        status_in = '0;
        fault_in = 12'h000;
        wd = 1'b0;
        n_errors = 0;
        check_count = 0;
        void'($urandom(54712));
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        repeat (5) @(posedge mclk);
        for (int b = 0; b < 2; b++) begin
            for (int a = 1; a < 8; a++) begin
                if (b == 1 && a == 6)
                    continue;
                d = 10'($urandom);
                wr(b[0], a[2:0], d, rx);
                wr(b[0], 3'h0, {7'h00, a[2:0]}, rx);
                wr(b[0], 3'h0, {7'h00, a[2:0]}, rx);
                if (a != 1)
                    chk(rx[13:0], {b[0], a[2:0], nm, d[8:0]});
            end
        end
        @(posedge mclk);
        nm <= 1'($urandom);
        status_in <= 7'($urandom);
        oah <= 2'($urandom);
        fault_in <= 12'($urandom);
        wr(1'b0, 3'h0, 10'h000, rx);
        wr(1'b0, 3'h0, 10'h000, rx);
        chk(rx[13:0], {4'h0, nm, status_in, oah});
        run({16'h0000, mk(wd, 1'b0, 3'h2, 10'h3FF) ^ 16'h4000}, 16, 0, rx);
        chk(cfg[0][2], m_cfg[0][2]);
        chk(par_fault, 1'b1);
        for (int n = 15; n <= 17; n += 2) begin
            run({16'h0000, mk(wd, 1'b0, 3'h2, 10'h155)}, n, 0, rx);
            chk(cfg[0][2], m_cfg[0][2]);
            // the first sixteen of seventeen bits hold an odd count of ones
            chk(par_fault, n == 17);
        end
        d = 10'($urandom);
        w = mk(wd, 1'b0, 3'h2, 10'h2AA);
        run({w, mk(wd, 1'b0, 3'h3, d)}, 32, 1, rx);
        m_cfg[0][3] = d;
        chk(cfg[0][3], m_cfg[0][3]);
        chk(cfg[0][2], m_cfg[0][2]);
        chk(rx[15:0], w);
        @(posedge mclk);
        nm <= 1'b1;
        temp_hi <= 1'b1;
        repeat (6) @(posedge mclk);
        chk(warn_flag, 1'b1);
        wr(1'b0, 3'h0, 10'h001, rx);
        @(posedge mclk);
        temp_hi <= 1'b0;
        repeat (6) @(posedge mclk);
        chk(warn_flag, 1'b1);
        wr(1'b0, 3'h0, 10'h001, rx);
        chk(rx[8:0], {3'b100, fault_in[5:0]});
        chk(warn_flag, 1'b0);
        wr(1'b1, 3'h0, 10'h001, rx);
        wr(1'b1, 3'h0, 10'h001, rx);
        chk(rx[5:0], fault_in[11:6]);
        @(posedge mclk);
        rst_n_pin <= 1'b0;
        repeat (6) @(posedge mclk);
        chk(cfg === '0, 1'b1);
        run({16'h0000, mk(wd, 1'b0, 3'h2, 10'h155)}, 16, 0, rx);
        chk(cfg === '0, 1'b1);
        close_out;
    end
endmodule : switch_spi_command_port_tb_top
